// [core/crs_register_set.sv]
// CPU programmer-visible register set
//
// Operation
// - Sixteen 32-bit general registers numbered 0 to 15 for data and addresses.
// - Register 0 supplies the index in both indexed indirect addressing modes.
// - Some instructions force register 0 as their only source or destination.
// - Register 15 is the stack pointer used by exception save and restore.
// - Three 32-bit control registers: status, global base, vector base.
// - Global base supplies base address for global-base indirect addressing.
// - Vector base supplies base address of the exception vector area.
// - Four 32-bit system registers are implemented.
// - System registers: mac high, mac low, return address, program counter.
// - Reset clears vector base, sets mask ones, loads pc and sp from vectors.
// - Stack accesses are aligned longwords only; misalignment is flagged.
`timescale 1ns/100ps
`include "crs_defines.svh"
module crs_register_set
	import crs_pkg::*;
#(
	parameter int DATA_W = `CRS_DATA_W
)
(
	// Clock and reset
	input  wire logic              I_CLK,
	input  wire logic              I_SYS_RST,
	// General register ports
	input  wire logic [3:0]        I_RA_SEL,
	input  wire logic [3:0]        I_RB_SEL,
	input  wire logic              I_RA_FORCE_IDX,
	input  wire logic              I_GPR_WE,
	input  wire logic [3:0]        I_GPR_WA,
	input  wire logic              I_GPR_WA_FORCE_IDX,
	input  wire logic [DATA_W-1:0] I_GPR_WD,
	output logic      [DATA_W-1:0] O_RA_DATA,
	output logic      [DATA_W-1:0] O_RB_DATA,
	// Special register ports
	input  wire logic              I_SPC_WE,
	input  wire logic [2:0]        I_SPC_WSEL,
	input  wire logic [DATA_W-1:0] I_SPC_WD,
	input  wire logic              I_PC_WE,
	input  wire logic [DATA_W-1:0] I_PC_WD,
	// Vector fetch during reset sequence
	input  wire logic              I_VEC_VALID,
	input  wire logic [DATA_W-1:0] I_VEC_DATA,
	// Stack access check
	input  wire logic              I_STK_REQ,
	input  wire logic [1:0]        I_STK_SIZE,
	input  wire logic [DATA_W-1:0] I_STK_ADDR,
	// Outputs
	output logic                   O_READY,
	output logic                   O_STK_ERR,
	output logic      [DATA_W-1:0] O_INDEX,
	output logic      [DATA_W-1:0] O_STACK_PTR,
	output logic      [DATA_W-1:0] O_STATUS,
	output logic      [DATA_W-1:0] O_GBASE,
	output logic      [DATA_W-1:0] O_VBASE,
	output logic      [DATA_W-1:0] O_MAC_RESULT_HIGH,
	output logic      [DATA_W-1:0] O_MAC_RESULT_LOW,
	output logic      [DATA_W-1:0] O_RET_ADDR,
	output logic      [DATA_W-1:0] O_PC
);
	// ****************************************************
	// Write arbitration
	// ****************************************************
	crs_state_type st_q;
	logic          vec_wr;
	logic          sp_vec_wr;
	logic [3:0]    wa;
	logic [3:0]    ra;
	logic          we;
	logic [DATA_W-1:0] wd;

	function automatic logic spc_hit(input logic en, input logic [2:0] s, input crs_sel_type t);
		spc_hit = en && (s == t);
	endfunction

	assign vec_wr    = (st_q != CRS_ST_RUN) && I_VEC_VALID;
	assign sp_vec_wr = vec_wr && st_q == CRS_ST_VEC_SP;
	assign wa = sp_vec_wr ? `CRS_STACK_REG : (I_GPR_WA_FORCE_IDX ? `CRS_IDX_REG : I_GPR_WA);
	assign we = sp_vec_wr || (I_GPR_WE && st_q == CRS_ST_RUN);
	assign wd = sp_vec_wr ? I_VEC_DATA : I_GPR_WD;
	assign ra = I_RA_FORCE_IDX ? `CRS_IDX_REG : I_RA_SEL;

	// ****************************************************
	// General registers
	// ****************************************************
	crs_gpr_bank #(.DATA_W(DATA_W), .NUM(`CRS_NUM_GPR)) u_bank
	(
		.i_clk (I_CLK),
		.i_we  (we),
		.i_wa  (wa),
		.i_wd  (wd),
		.i_ra  (ra),
		.i_rb  (I_RB_SEL),
		.o_rda (O_RA_DATA),
		.o_rdb (O_RB_DATA)
	);

	// Shadow copies of index and stack registers for direct outputs
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
			O_INDEX <= '0;
		else if (we && wa == `CRS_IDX_REG)
			O_INDEX <= wd;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
			O_STACK_PTR <= '0;
		else if (we && wa == `CRS_STACK_REG)
			O_STACK_PTR <= wd;
	end

	// ****************************************************
	// Reset vector sequence
	// ****************************************************
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
			st_q <= CRS_ST_VEC_PC;
		else if (vec_wr)
		begin
			unique case (st_q)
				CRS_ST_VEC_PC: st_q <= CRS_ST_VEC_SP;
				CRS_ST_VEC_SP: st_q <= CRS_ST_RUN;
				CRS_ST_RUN:    st_q <= CRS_ST_RUN;
			endcase
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
			O_READY <= 1'b0;
		else
			O_READY <= (st_q == CRS_ST_RUN) || sp_vec_wr;
	end

	// ****************************************************
	// Control registers
	// ****************************************************
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
			O_STATUS <= `CRS_SR_RST;
		else if (spc_hit(I_SPC_WE, I_SPC_WSEL, CRS_SEL_STATUS))
			O_STATUS <= I_SPC_WD & `CRS_SR_VALID_MASK;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
			O_GBASE <= '0;
		else if (spc_hit(I_SPC_WE, I_SPC_WSEL, CRS_SEL_GBASE))
			O_GBASE <= I_SPC_WD;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
			O_VBASE <= `CRS_VBR_RST;
		else if (spc_hit(I_SPC_WE, I_SPC_WSEL, CRS_SEL_VBASE))
			O_VBASE <= I_SPC_WD;
	end

	// ****************************************************
	// System registers
	// ****************************************************
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
			O_MAC_RESULT_HIGH <= '0;
		else if (spc_hit(I_SPC_WE, I_SPC_WSEL, CRS_SEL_MAC_RESULT_HIGH))
			O_MAC_RESULT_HIGH <= I_SPC_WD;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
			O_MAC_RESULT_LOW <= '0;
		else if (spc_hit(I_SPC_WE, I_SPC_WSEL, CRS_SEL_MAC_RESULT_LOW))
			O_MAC_RESULT_LOW <= I_SPC_WD;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
			O_RET_ADDR <= '0;
		else if (spc_hit(I_SPC_WE, I_SPC_WSEL, CRS_SEL_RET))
			O_RET_ADDR <= I_SPC_WD;
	end

	// PC from vector first, then datapath; PC port wins over select port
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
			O_PC <= '0;
		else if (vec_wr && st_q == CRS_ST_VEC_PC)
			O_PC <= I_VEC_DATA;
		else if (st_q == CRS_ST_RUN && I_PC_WE)
			O_PC <= I_PC_WD;
		else if (st_q == CRS_ST_RUN && spc_hit(I_SPC_WE, I_SPC_WSEL, CRS_SEL_PC))
			O_PC <= I_SPC_WD;
	end

	// ****************************************************
	// Stack access check
	// ****************************************************
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
			O_STK_ERR <= 1'b0;
		else
			O_STK_ERR <= I_STK_REQ && (I_STK_SIZE != 2'h2 || I_STK_ADDR[1:0] != 2'h0);
	end
endmodule // crs_register_set

// [core/crs_defines.svh]
// Constants for the CPU register set
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH
`define CRS_DATA_W        32
`define CRS_NUM_GPR       16
`define CRS_IDX_REG       4'h0
`define CRS_STACK_REG     4'hF
`define CRS_VBR_RST       32'h0000_0000
`define CRS_SR_IMASK_LSB  4
`define CRS_SR_IMASK_MSB  7
`define CRS_SR_IMASK_RST  4'hF
`define CRS_SR_VALID_MASK 32'h0000_03F3
`define CRS_SR_RST        32'h0000_00F0
`define CRS_SEL_W         3
`endif

// [core/crs_pkg.sv]
// Types for the CPU register set
package crs_pkg;
	typedef enum logic [2:0]
	{
		CRS_SEL_STATUS,
		CRS_SEL_GBASE,
		CRS_SEL_VBASE,
		CRS_SEL_MAC_RESULT_HIGH,
		CRS_SEL_MAC_RESULT_LOW,
		CRS_SEL_RET,
		CRS_SEL_PC,
		CRS_SEL_NONE
	} crs_sel_type;
	typedef enum logic [1:0]
	{
		CRS_ST_VEC_PC,
		CRS_ST_VEC_SP,
		CRS_ST_RUN
	} crs_state_type;
endpackage

// [core/crs_gpr_bank.sv]
// Sixteen-entry general register array, two read and one write port
`timescale 1ns/100ps
`include "crs_defines.svh"
module crs_gpr_bank
#(
	parameter int DATA_W = `CRS_DATA_W,
	parameter int NUM    = `CRS_NUM_GPR
)
(
	// Clock
	input  wire logic                     i_clk,
	// Write port
	input  wire logic                     i_we,
	input  wire logic [$clog2(NUM)-1:0]   i_wa,
	input  wire logic [DATA_W-1:0]        i_wd,
	// Read ports
	input  wire logic [$clog2(NUM)-1:0]   i_ra,
	input  wire logic [$clog2(NUM)-1:0]   i_rb,
	output logic      [DATA_W-1:0]        o_rda,
	output logic      [DATA_W-1:0]        o_rdb
);
	logic [DATA_W-1:0] mem_q [NUM];

	// Registered reads with write bypass
	always_ff @(posedge i_clk)
	begin
		if (i_we)
			mem_q[i_wa] <= i_wd;
	end

	always_ff @(posedge i_clk)
	begin
		o_rda <= (i_we && i_wa == i_ra) ? i_wd : mem_q[i_ra];
		o_rdb <= (i_we && i_wa == i_rb) ? i_wd : mem_q[i_rb];
	end
endmodule // crs_gpr_bank

// [verification/crs_register_set_monitor.sv]
// Port assertions for the CPU register set
`timescale 1ns/100ps
module crs_register_set_monitor
(
	// Clock, reset, inputs
	input wire logic        I_CLK,
	input wire logic        I_SYS_RST,
	input wire logic        I_GPR_WE,
	input wire logic [3:0]  I_GPR_WA,
	input wire logic        I_GPR_WA_FORCE_IDX,
	input wire logic [31:0] I_GPR_WD,
	input wire logic        I_SPC_WE,
	input wire logic [2:0]  I_SPC_WSEL,
	input wire logic [31:0] I_SPC_WD,
	input wire logic        I_PC_WE,
	input wire logic [31:0] I_PC_WD,
	input wire logic        I_STK_REQ,
	input wire logic [1:0]  I_STK_SIZE,
	input wire logic [31:0] I_STK_ADDR,
	// Outputs
	input wire logic        O_READY,
	input wire logic        O_STK_ERR,
	input wire logic [31:0] O_INDEX,
	input wire logic [31:0] O_STACK_PTR,
	input wire logic [31:0] O_STATUS,
	input wire logic [31:0] O_GBASE,
	input wire logic [31:0] O_VBASE,
	input wire logic [31:0] O_PC
);
	// ****
	// Checks
	// ****
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);
	a_reset_values: assert property (disable iff (1'b0)
		I_SYS_RST |=> !O_READY && O_VBASE == '0 && O_STATUS == 32'h0000_00F0) else $error("bad reset values");
	a_status_mask: assert property (I_SPC_WE && I_SPC_WSEL == 3'h0
		|=> O_STATUS == ($past(I_SPC_WD) & 32'h0000_03F3)) else $error("status write wrong");
	a_gbase_load: assert property (I_SPC_WE && I_SPC_WSEL == 3'h1
		|=> O_GBASE == $past(I_SPC_WD)) else $error("global base write wrong");
	a_vbase_load: assert property (I_SPC_WE && I_SPC_WSEL == 3'h2
		|=> O_VBASE == $past(I_SPC_WD)) else $error("vector base write wrong");
	a_pc_port: assert property (O_READY && I_PC_WE |=> O_PC == $past(I_PC_WD))
		else $error("pc write wrong");
	a_pc_select: assert property (O_READY && I_SPC_WE && I_SPC_WSEL == 3'h6 && !I_PC_WE
		|=> O_PC == $past(I_SPC_WD)) else $error("pc select write wrong");
	a_ready_hold: assert property (O_READY |=> O_READY) else $error("ready dropped");
	a_index_write: assert property (O_READY && I_GPR_WE && (I_GPR_WA_FORCE_IDX || I_GPR_WA == 4'h0)
		|=> O_INDEX == $past(I_GPR_WD)) else $error("index copy wrong");
	a_stack_write: assert property (O_READY && I_GPR_WE && !I_GPR_WA_FORCE_IDX && I_GPR_WA == 4'hF
		|=> O_STACK_PTR == $past(I_GPR_WD)) else $error("stack copy wrong");
	a_stack_align: assert property (I_STK_REQ
		|=> O_STK_ERR == ($past(I_STK_SIZE) != 2'h2 || $past(I_STK_ADDR[1:0]) != 2'h0)) else $error("stack flag wrong");
endmodule // crs_register_set_monitor
bind crs_register_set crs_register_set_monitor mon (.*);

// [verification/crs_vec_source.sv]
// Reset vector source standing in for the exception sequencer
`timescale 1ns/100ps
module crs_vec_source
#(
	parameter logic [31:0] PC_VEC = 32'h0000_0400,
	parameter logic [31:0] SP_VEC = 32'h0000_3FFC
)
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Vector words
	output logic             o_vec_valid,
	output logic      [31:0] o_vec_data
);
	logic [1:0] step_q;
	// ****
	// PC word, gap, SP word, then idle
	// ****
	always_ff @(posedge i_clk)
	begin
		step_q <= i_rst ? 2'h0 : step_q + {1'b0, step_q != 2'h3};
		o_vec_valid <= !i_rst && !step_q[0];
		o_vec_data <= (step_q == 2'h0) ? PC_VEC : (step_q == 2'h2) ? SP_VEC : ~o_vec_data;
	end
endmodule // crs_vec_source

// [verification/crs_register_set_tb.sv]
// Self-checking bench for the CPU register set
`timescale 1ns/100ps
module crs_register_set_tb;
	localparam logic [31:0] PC_VEC = 32'h0000_0400;
	localparam logic [31:0] SP_VEC = 32'h0000_3FFC;
	logic        I_CLK = 0, I_SYS_RST = 1, I_RA_FORCE_IDX = 0, I_GPR_WE = 0, I_GPR_WA_FORCE_IDX = 0;
	logic        I_SPC_WE = 0, I_PC_WE = 0, I_VEC_VALID, I_STK_REQ = 0, O_READY, O_STK_ERR;
	logic [3:0]  I_RA_SEL = '0, I_RB_SEL = '0, I_GPR_WA = '0;
	logic [2:0]  I_SPC_WSEL = 3'h7;
	logic [1:0]  I_STK_SIZE = 2'h2;
	logic [31:0] I_GPR_WD = '0, I_SPC_WD = '0, I_PC_WD = '0, I_VEC_DATA, I_STK_ADDR = '0;
	logic [31:0] O_RA_DATA, O_RB_DATA, O_INDEX, O_STACK_PTR, O_STATUS, O_GBASE, O_VBASE, O_MAC_RESULT_HIGH, O_MAC_RESULT_LOW;
	logic [31:0] O_RET_ADDR, O_PC;
	int          error_cnt = 0, n_checks = 0;
	always #2 I_CLK = ~I_CLK;
	crs_register_set dut (.*);
	crs_vec_source #(.PC_VEC(PC_VEC), .SP_VEC(SP_VEC)) vec (.i_clk(I_CLK), .i_rst(I_SYS_RST),
		.o_vec_valid(I_VEC_VALID), .o_vec_data(I_VEC_DATA));
	// ****
	// Scenarios
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic t_boot;
		int n;
		repeat (12) @(posedge I_CLK);
		#1;
		chk(O_VBASE, '0);
		chk(O_STATUS, 32'h0000_00F0);
		@(posedge I_CLK);
		I_SYS_RST <= 1'b0;
		I_GPR_WE <= 1'b1;
		I_GPR_WD <= 32'hDEAD_BEEF;
		@(posedge I_CLK);
		I_GPR_WE <= 1'b0;
		for (n = 0; n < 20 && O_READY !== 1'b1; n++)
		begin
			@(posedge I_CLK);
			#1;
		end
		if (O_READY !== 1'b1)
		begin
			error_cnt++;
			$display("unexpected at %0t: no ready", $time);
			test_done;
		end
		chk(O_PC, PC_VEC);
		chk(O_STACK_PTR, SP_VEC);
		chk(O_INDEX, '0);
		$display("boot test done");
	endtask
	task automatic t_rerun;
		int n;
		@(posedge I_CLK);
		I_SYS_RST <= 1'b1;
		repeat (2) @(posedge I_CLK);
		#1;
		chk(O_STATUS, 32'h0000_00F0);
		chk(O_VBASE, '0);
		chk({31'h0, O_READY}, '0);
		@(posedge I_CLK);
		I_SYS_RST <= 1'b0;
		for (n = 0; n < 20 && O_READY !== 1'b1; n++)
		begin
			@(posedge I_CLK);
			#1;
		end
		if (O_READY !== 1'b1)
		begin
			error_cnt++;
			$display("unexpected at %0t: no ready after reset", $time);
			test_done;
		end
		chk(O_PC, PC_VEC);
		chk(O_STACK_PTR, SP_VEC);
		chk(O_MAC_RESULT_HIGH, '0);
		$display("reset rerun test done");
	endtask
	task automatic t_gpr;
		int i;
		for (i = 0; i < 16; i++)
		begin
			@(posedge I_CLK);
			I_GPR_WE <= 1'b1;
			I_GPR_WA <= i[3:0];
			I_GPR_WD <= {4{i[3:0], 4'hA}};
		end
		@(posedge I_CLK);
		I_GPR_WE <= 1'b0;
		#1;
		chk(O_INDEX, 32'h0A0A_0A0A);
		chk(O_STACK_PTR, 32'hFAFA_FAFA);
		for (i = 0; i < 16; i++)
		begin
			@(posedge I_CLK);
			I_RA_SEL <= i[3:0];
			I_RB_SEL <= 4'hF - i[3:0];
			@(posedge I_CLK);
			#1;
			chk(O_RA_DATA, {4{i[3:0], 4'hA}});
			chk(O_RB_DATA, {4{4'hF - i[3:0], 4'hA}});
		end
		@(posedge I_CLK);
		{I_GPR_WE, I_GPR_WA_FORCE_IDX, I_RA_FORCE_IDX} <= 3'h7;
		I_GPR_WA <= 4'h7;
		I_RB_SEL <= 4'h7;
		I_GPR_WD <= 32'h1234_5678;
		@(posedge I_CLK);
		{I_GPR_WE, I_GPR_WA_FORCE_IDX, I_RA_FORCE_IDX} <= 3'h0;
		#1;
		chk(O_INDEX, 32'h1234_5678);
		chk(O_RA_DATA, 32'h1234_5678);
		chk(O_RB_DATA, 32'h7A7A_7A7A);
		$display("general register test done");
	endtask
	task automatic t_spc;
		int s;
		for (s = 0; s < 7; s++)
		begin
			@(posedge I_CLK);
			I_SPC_WE <= 1'b1;
			I_SPC_WSEL <= s[2:0];
			I_SPC_WD <= {28'hFFF_FFFF, s[3:0]};
		end
		@(posedge I_CLK);
		{I_SPC_WE, I_PC_WE} <= 2'h3;
		I_PC_WD <= 32'h0000_2000;
		@(posedge I_CLK);
		{I_SPC_WE, I_PC_WE} <= 2'h0;
		#1;
		chk(O_STATUS, 32'h0000_03F0);
		chk(O_GBASE, 32'hFFFF_FFF1);
		chk(O_VBASE, 32'hFFFF_FFF2);
		chk(O_MAC_RESULT_HIGH, 32'hFFFF_FFF3);
		chk(O_MAC_RESULT_LOW, 32'hFFFF_FFF4);
		chk(O_RET_ADDR, 32'hFFFF_FFF5);
		chk(O_PC, 32'h0000_2000);
		$display("special register test done");
	endtask
	task automatic t_stack;
		logic [1:0] sz [4] = '{2'h2, 2'h2, 2'h1, 2'h0};
		logic [1:0] lo [4] = '{2'h0, 2'h2, 2'h0, 2'h1};
		int k;
		for (k = 0; k < 5; k++)
		begin
			@(posedge I_CLK);
			I_STK_REQ <= k < 4;
			I_STK_SIZE <= sz[k % 4];
			I_STK_ADDR <= {30'h0000_0FF0, lo[k % 4]};
			@(posedge I_CLK);
			#1;
			chk({31'h0, O_STK_ERR}, {31'h0, k == 1 || k == 2 || k == 3});
		end
		$display("stack check test done");
	endtask
	initial
	begin
		t_boot;
		t_gpr;
		t_spc;
		t_stack;
		t_rerun;
		test_done;
	end
endmodule // crs_register_set_tb
